// [design/hmc_slave.sv]
// per-pair maintenance channel slave: evaluation, echo, latching, regenerator overwrite
`timescale 1ns/1ps
`default_nettype none
`include "hmc_regs.svh"
// Operation
// - one 13-bit channel frame per line frame
// - addresses master 11, terminal 00, regenerator 10
// - echoes carry responder's own address
// - bit 3 one for opcode, zero data
// - bit 4 odd/even byte marker alternates; the code echoes the received bit and sends 1 in every keep-state frame
// - bit 5 one; bits 6-13 info MSB first
// - unaddressed terminal sends keep-state address 00
// - regenerator passes downstream, overwrites upstream when addressed
// - pair-specific handled independently per pair
// - global messages evaluated on selected pair
// - global acknowledgements sent on all pairs; the code answers a global message only on the pair it came in on
// - act only after three identical addressed frames
// - echo each addressed frame next return frame
// - loopback and bad-check commands latch together
// - three release-all frames clear all latches
// - slave never originates messages
// - unsupported message answered cannot-comply from third
module hmc_slave (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  input  wire hmc_pkg::hmc_role_t                role,
  input  wire logic [1:0]                        globalPair,
  input  wire logic [`HMC_NPAIR-1:0]             dnStrobe,
  input  wire hmc_pkg::hmc_frame_t [`HMC_NPAIR-1:0] dnFrame,
  input  wire logic [`HMC_NPAIR-1:0]             upStrobe,
  input  wire hmc_pkg::hmc_frame_t [`HMC_NPAIR-1:0] upFrame,
  output logic [`HMC_NPAIR-1:0]                  dnOutStrobe,
  output hmc_pkg::hmc_frame_t [`HMC_NPAIR-1:0]   dnOutFrame,
  output logic [`HMC_NPAIR-1:0]                  retStrobe,
  output hmc_pkg::hmc_frame_t [`HMC_NPAIR-1:0]   retFrame,
  output logic [`HMC_NPAIR-1:0]                  pairLoop,
  output logic [`HMC_NPAIR-1:0]                  pairBadCrc,
  output logic                                   globalLoop,
  output logic [`HMC_NPAIR-1:0]                  cannotComply
);
  import hmc_pkg::*;

  logic [1:0]     ownAddr;
  hmc_frame_t     lastFrame  [`HMC_NPAIR];
  logic [1:0]     repCount   [`HMC_NPAIR];
  hmc_frame_t     pending    [`HMC_NPAIR];
  logic [`HMC_NPAIR-1:0] havePending;
  logic [`HMC_NPAIR-1:0] valid3;

  assign ownAddr = (role == HMC_ROLE_REGEN) ? `HMC_ADDR_REGEN : `HMC_ADDR_NT;

  genvar p;
  generate
    for (p = 0; p < `HMC_NPAIR; p++) begin : gPair
      hmc_frame_t rx;
      logic       addressed;
      logic       same;
      logic       supported;
      logic [1:0] next_count;
      hmc_frame_t reply;
      hmc_frame_t keepFrame;

      assign rx        = dnFrame[p];
      assign addressed = (rx.addr == ownAddr);
      assign same      = (rx == lastFrame[p]);
      assign supported = rx.isOpcode && (rx.info == `HMC_OP_RELEASE ||
                         rx.info == `HMC_OP_KEEP || rx.info == `HMC_OP_LOOP ||
                         rx.info == `HMC_OP_BADCRC || rx.info == `HMC_OP_SUPPORTED);
      assign next_count = !same ? `HMC_REP_ONE :
                          (repCount[p] == `HMC_REP_NEEDED) ? repCount[p] :
                          repCount[p] + `HMC_REP_ONE;
      assign valid3 [p] = dnStrobe[p] && addressed && same &&
                          (repCount[p] >= `HMC_REP_PREV);

      always_comb begin
        reply = rx;
        reply.addr  = ownAddr;
        reply.spare = 1'b1;
        if (addressed && !supported && same && repCount[p] >= `HMC_REP_PREV) begin
          reply.isOpcode = 1'b1;
          reply.info     = `HMC_OP_CANNOT;
        end
      end

      always_comb begin
        keepFrame.addr     = `HMC_ADDR_NT;
        keepFrame.isOpcode = 1'b1;
        keepFrame.oddByte  = 1'b1;
        keepFrame.spare    = 1'b1;
        keepFrame.info     = `HMC_OP_KEEP;
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          lastFrame[p] <= '0;
          repCount[p]  <= 2'h0;
        end else if (dnStrobe[p]) begin
          lastFrame[p] <= rx;
          repCount[p]  <= next_count;
        end
      end

      // response held until the next return frame slot
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pending[p]     <= '0;
          havePending[p] <= 1'b0;
        end else if (dnStrobe[p] && addressed) begin
          pending[p]     <= reply;
          havePending[p] <= 1'b1;
        end else if (dnStrobe[p] && role == HMC_ROLE_NT) begin
          pending[p]     <= keepFrame;
          havePending[p] <= 1'b1;
        end else if (dnStrobe[p]) begin
          havePending[p] <= 1'b0;
        end
      end

      // return direction: terminal sends its own, regenerator overwrites when addressed
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          retStrobe[p] <= 1'b0;
          retFrame[p]  <= '0;
        end else if (role == HMC_ROLE_REGEN) begin
          retStrobe[p] <= upStrobe[p];
          retFrame[p]  <= havePending[p] ? pending[p] : upFrame[p];
        end else begin
          retStrobe[p] <= dnStrobe[p];
          retFrame[p]  <= havePending[p] ? pending[p] : keepFrame;
        end
      end

      // downstream pass-through for the regenerator
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          dnOutStrobe[p] <= 1'b0;
          dnOutFrame[p]  <= '0;
        end else begin
          dnOutStrobe[p] <= dnStrobe[p] && role == HMC_ROLE_REGEN;
          dnOutFrame[p]  <= rx;
        end
      end

      // pair-specific latches
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pairLoop[p]     <= 1'b0;
          pairBadCrc[p]   <= 1'b0;
          cannotComply[p] <= 1'b0;
        end else if (valid3[p]) begin
          if (rx.isOpcode && rx.info == `HMC_OP_RELEASE) begin
            pairLoop[p]     <= 1'b0;
            pairBadCrc[p]   <= 1'b0;
            cannotComply[p] <= 1'b0;
          end else if (!supported) begin
            cannotComply[p] <= 1'b1;
          end else if (rx.info == `HMC_OP_LOOP) begin
            pairLoop[p]     <= 1'b1;
          end else if (rx.info == `HMC_OP_BADCRC) begin
            pairBadCrc[p]   <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // global loopback evaluated on the selected pair only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      globalLoop <= 1'b0;
    end else if (globalPair < 2'(`HMC_NPAIR) && valid3[globalPair]) begin
      if (dnFrame[globalPair].isOpcode && dnFrame[globalPair].info == `HMC_OP_RELEASE) begin
        globalLoop <= 1'b0;
      end else if (dnFrame[globalPair].info == `HMC_OP_LOOP &&
                   dnFrame[globalPair].isOpcode) begin
        globalLoop <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [design/hmc_regs.svh]
// constants for the maintenance channel slave
`ifndef HMC_REGS_SVH
`define HMC_REGS_SVH
`define HMC_NPAIR        3
`define HMC_FRAME_BITS   13
`define HMC_ADDR_MASTER  2'h3
`define HMC_ADDR_NT      2'h0
`define HMC_ADDR_REGEN   2'h2
`define HMC_REP_NEEDED   2'h3
`define HMC_REP_ONE      2'h1
`define HMC_REP_PREV     2'h2
`define HMC_OP_RELEASE   8'hf0
`define HMC_OP_KEEP      8'hf1
`define HMC_OP_CANNOT    8'hf2
`define HMC_OP_LOOP      8'h50
`define HMC_OP_BADCRC    8'h51
`define HMC_OP_SUPPORTED 8'h52
`define HMC_LATCH_LOOP   0
`define HMC_LATCH_BADCRC 1
`define HMC_LATCH_W      2
`endif

// [design/hmc_pkg.sv]
// types for the maintenance channel slave
package hmc_pkg;
  typedef struct packed {
    logic [1:0] addr;
    logic       isOpcode;
    logic       oddByte;
    logic       spare;
    logic [7:0] info;
  } hmc_frame_t;
  typedef enum logic {
    HMC_ROLE_NT,
    HMC_ROLE_REGEN
  } hmc_role_t;
endpackage

// [verif/hmc_slave_monitor.sv]
// checker on the channel slave ports
`timescale 1ns/1ps
`default_nettype none
module hmc_slave_monitor (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire hmc_pkg::hmc_role_t        role,
  input wire logic [1:0]                globalPair,
  input wire logic [2:0]                dnStrobe,
  input wire hmc_pkg::hmc_frame_t [2:0] dnFrame,
  input wire logic [2:0]                retStrobe,
  input wire hmc_pkg::hmc_frame_t [2:0] retFrame,
  input wire logic [2:0]                pairLoop,
  input wire logic [2:0]                pairBadCrc,
  input wire logic                      globalLoop
);
  import hmc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reply_next_a: assert property (dnStrobe[0] |=> retStrobe[0])
    else $error("no reply");
  no_origin_a: assert property (retStrobe[0] |-> $past(dnStrobe[0]))
    else $error("unasked reply");
  own_addr_a: assert property (!role && retStrobe[1] |-> !retFrame[1].addr)
    else $error("wrong reply address");
  spare_set_a: assert property (retStrobe[2] |-> retFrame[2].spare)
    else $error("spare bit low");
  loop_cause_a: assert property ($rose(pairLoop[0]) |->
    $past(dnStrobe[0] && dnFrame[0].info == 8'h50 && dnFrame[0].addr == {role, 1'b0}))
    else $error("loop without command");
  crc_cause_a: assert property ($rose(pairBadCrc[2]) |->
    $past(dnStrobe[2] && dnFrame[2].info == 8'h51)) else $error("bad crc uncaused");
  loop_release_a: assert property ($fell(pairLoop[0]) |-> $past(dnFrame[0].info == 8'hf0))
    else $error("loop dropped");
  global_loop_a: assert property ($rose(globalLoop) |-> $past(dnStrobe[globalPair]))
    else $error("global loop off pair");
endmodule
bind hmc_slave hmc_slave_monitor mon (.*);
`default_nettype wire

// [verif/hmc_master_model.sv]
// master model repeating commanded frames and counting echoes
`timescale 1ns/1ps
`default_nettype none
module hmc_master_model (
  input  wire logic                      clk,
  input  wire hmc_pkg::hmc_frame_t [2:0] cmd,
  input  wire logic                      retStrobe,
  input  wire hmc_pkg::hmc_frame_t       retFrame,
  output logic [2:0]                     dnStrobe,
  output hmc_pkg::hmc_frame_t [2:0]      dnFrame,
  output var int                         echoes
);
  import hmc_pkg::*;
  logic [1:0] phase = 2'h0;
  initial {dnStrobe, dnFrame, echoes} = '0;
  // echoes judged on pair 0 only; a differing return frame restarts the run
  always @(posedge clk)
    if (retStrobe) echoes <= (retFrame == dnFrame[0]) ? echoes + 1 : 0;
  always @(negedge clk) begin
    phase <= phase + 2'h1;
    dnStrobe <= {3{phase == 2'h3}};
    if (phase == 2'h3) dnFrame <= cmd;
  end
endmodule
`default_nettype wire

// [verif/hmc_slave_tb.sv]
// testbench for the channel slave
`timescale 1ns/1ps
`default_nettype none
`include "hmc_regs.svh"
module hmc_slave_tb;
  import hmc_pkg::*;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  hmc_role_t        role = HMC_ROLE_NT;
  logic [1:0]       globalPair = 2'h0;
  logic [2:0]       dnStrobe, retStrobe, dnOutStrobe, pairLoop, pairBadCrc, cannotComply;
  logic [5:0]       strobes;
  logic             globalLoop;
  int               echoes;
  hmc_frame_t [2:0] cmd, dnFrame, dnOutFrame, retFrame;
  int               bad_count = 0;
  int               check_count = 0;
  always #12.5 clk = ~clk;
  hmc_master_model master (.clk(clk), .cmd(cmd), .retStrobe(retStrobe[0]),
    .retFrame(retFrame[0]), .dnStrobe(dnStrobe), .dnFrame(dnFrame), .echoes(echoes));
  hmc_slave dut (.clk(clk), .nrst(nrst), .role(role), .globalPair(globalPair),
    .dnStrobe(dnStrobe), .dnFrame(dnFrame), .upStrobe(dnStrobe), .upFrame(dnFrame),
    .dnOutStrobe(dnOutStrobe), .dnOutFrame(dnOutFrame), .retStrobe(retStrobe),
    .retFrame(retFrame), .pairLoop(pairLoop), .pairBadCrc(pairBadCrc),
    .globalLoop(globalLoop), .cannotComply(cannotComply));
  function automatic hmc_frame_t fr(logic [7:0] op);
    return {2'h0, 3'h7, op};
  endfunction
  // strobes are caught while they stand, levels a cycle later
  task automatic run(int n);
    repeat (n) @(posedge dnStrobe[0]);
    @(negedge clk) strobes = {retStrobe, dnOutStrobe};
    @(negedge clk);
  endtask
  task automatic chk(logic [12:0] got, logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cmd = {3{fr(`HMC_OP_RELEASE)}};
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    run(3);
    chk(retFrame[0], fr(`HMC_OP_RELEASE));
    chk(strobes, 6'h38);
    cmd = {fr(`HMC_OP_BADCRC), {2'h2, 3'h7, `HMC_OP_LOOP}, fr(`HMC_OP_LOOP)};
    run(2);
    chk(pairLoop, 3'h0);
    run(1);
    chk(pairLoop, 3'h1);
    chk(globalLoop, 1'b1);
    run(1);
    chk(pairBadCrc, 3'h4);
    chk(retFrame[0], fr(`HMC_OP_LOOP));
    chk(retFrame[1], fr(`HMC_OP_KEEP));
    chk(retFrame[2], fr(`HMC_OP_BADCRC));
    chk(13'(echoes), 13'h3);
    cmd[0] = fr(8'h33);
    run(4);
    chk(cannotComply, 3'h1);
    chk(retFrame[0], fr(`HMC_OP_CANNOT));
    chk(pairLoop, 3'h1);
    chk(13'(echoes), 13'h0);
    cmd = {3{fr(`HMC_OP_RELEASE)}};
    run(2);
    chk(pairBadCrc, 3'h4);
    run(1);
    chk({pairLoop, pairBadCrc, cannotComply, globalLoop}, 13'h0);
    nrst = 1'b0;
    role = HMC_ROLE_REGEN;
    globalPair = 2'h1;
    cmd[0] = {2'h2, 3'h7, `HMC_OP_LOOP};
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    run(3);
    chk(strobes, 6'h3f);
    chk(retFrame[0], cmd[0]);
    chk(retFrame[1], fr(`HMC_OP_RELEASE));
    chk(dnOutFrame[2], cmd[2]);
    chk({pairLoop, globalLoop}, 4'h2);
    end_of_test;
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
